// ---- pkg/aus_params.svh ----
// Constants of the asynchronous serial block: bit timing and register map.
// Assumes it is included by bare name wherever the values are needed.
`ifndef AUS_PARAMS_SVH
`define AUS_PARAMS_SVH

// Sixteen bit-clock ticks per bit; half a bit is eight ticks.
`define AUS_TICK_LAST 4'hF
`define AUS_HALF_LAST 4'h7

// Register port offsets.
`define AUS_REG_STATUS 4'h0
`define AUS_REG_MASK 4'h4

// Status and mask bit positions.
`define AUS_ST_RXAVAIL 0
`define AUS_ST_OVERRUN 1
`define AUS_ST_PARITY 2
`define AUS_ST_FRAMING 3
`define AUS_ST_TXDONE 4
`define AUS_ST_W 5
`define AUS_MASK_RST 5'h00

`endif

// ---- pkg/aus_pkg.sv ----
// Types and shared helpers of the asynchronous serial block.
// Assumes nothing beyond a SystemVerilog compiler.
package aus_pkg;

    typedef enum logic {TX_IDLE, TX_BUSY} aus_tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_VERIFY, RX_SHIFT} aus_rx_state_t;

    // Every asynchronous pin, gathered so one synchroniser serves them all.
    typedef struct packed {
        logic initIn;
        logic txClk;
        logic rxClk;
        logic [7:0] txData;
        logic loadN;
        logic ctrlStb;
        logic parOmit;
        logic parSel;
        logic lenLo;
        logic lenHi;
        logic stopTwo;
        logic rxIn;
        logic clrN;
        logic flagsEnN;
        logic dataEnN;
    } aus_pins_t;

    function automatic logic [3:0] wordBits(input logic [1:0] sel);
        return 4'h5 + {2'h0, sel};
    endfunction

    function automatic logic parityBit(input logic [7:0] d, input logic [3:0] n, input logic even);
        logic [7:0] m;
        m = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (4'(i) < n) m[i] = d[i];
        end
        return even ? ^m : ~^m;
    endfunction

endpackage

// ---- pkg/aus_cfg_if.sv ----
// Character format shared by the transmitter and the receiver.
// Assumes the top module drives it from its latched control bits.
`timescale 1ns/1ps
interface aus_cfg_if;
    logic [1:0] lenSel;
    logic parityOn;
    logic parityEven;
    logic twoStop;
    modport ctl (output lenSel, parityOn, parityEven, twoStop);
    modport sink (input lenSel, parityOn, parityEven, twoStop);
endinterface

// ---- core/aus_tx.sv ----
// Double-buffered transmitter: holding register plus frame shifter.
// Assumes synchronised strobe levels and one-cycle bit-clock edge pulses.
`timescale 1ns/1ps
`include "aus_params.svh"
module aus_tx (
    // Clock and block init
    input wire logic sys_clk,
    input wire logic init,
    // Bit-clock edges
    input wire logic txFall,
    input wire logic txRise,
    // Holding register load
    input wire logic loadLow,
    input wire logic loadRelease,
    input wire logic [7:0] loadData,
    // Character format
    aus_cfg_if.sink cfg,
    // Line and status
    output logic serialOut,
    output logic charDone,
    output logic holdEmpty
);
    logic [7:0] holdReg;
    logic holdFull;
    logic [11:0] frame;
    logic [11:0] next_frame;
    logic [3:0] tick;
    logic [3:0] bitsLeft;
    logic [3:0] nBits;
    logic endTick;
    logic transfer;
    aus_pkg::aus_tx_state_t state;

    assign nBits = aus_pkg::wordBits(cfg.lenSel);
    // The second stop bit of a five-bit character lasts half a bit.
    assign endTick = state == aus_pkg::TX_BUSY && bitsLeft == 4'h1
        && (tick == `AUS_TICK_LAST || (cfg.twoStop && nBits == 4'h5 && tick == `AUS_HALF_LAST));
    assign transfer = txFall && holdFull && (state == aus_pkg::TX_IDLE || endTick);
    assign serialOut = frame[0];
    assign holdEmpty = !holdFull;

    always_comb begin
        next_frame = 12'hFFF;
        next_frame[0] = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (4'(i) < nBits) next_frame[i + 1] = holdReg[i];
        end
        if (cfg.parityOn) next_frame[nBits + 4'h1] = aus_pkg::parityBit(holdReg, nBits, cfg.parityEven);
    end

    always_ff @(posedge sys_clk) begin
        if (init) begin
            holdReg <= 8'h00;
            holdFull <= 1'b0;
        end else begin
            if (loadLow) holdReg <= loadData;
            if (transfer) holdFull <= 1'b0;
            if (loadRelease) holdFull <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (init) begin
            state <= aus_pkg::TX_IDLE;
            frame <= 12'hFFF;
            tick <= 4'h0;
            bitsLeft <= 4'h0;
        end else if (txFall) begin
            if (transfer) begin
                state <= aus_pkg::TX_BUSY;
                frame <= next_frame;
                tick <= 4'h0;
                bitsLeft <= 4'h2 + nBits + {3'h0, cfg.parityOn} + {3'h0, cfg.twoStop};
            end else if (endTick) begin
                state <= aus_pkg::TX_IDLE;
                frame <= 12'hFFF;
            end else if (state == aus_pkg::TX_BUSY) begin
                if (tick == `AUS_TICK_LAST) begin
                    tick <= 4'h0;
                    frame <= {1'b1, frame[11:1]};
                    bitsLeft <= bitsLeft - 4'h1;
                end else begin
                    tick <= tick + 4'h1;
                end
            end
        end
    end

    // In back-to-back sending the done flag lasts only until the next rising bit-clock edge.
    always_ff @(posedge sys_clk) begin
        if (init) begin
            charDone <= 1'b1;
        end else if (txFall && endTick) begin
            charDone <= 1'b1;
        end else if (txFall && transfer) begin
            charDone <= 1'b0;
        end else if (txRise && state == aus_pkg::TX_BUSY) begin
            charDone <= 1'b0;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (init);

    property p_start_edge;
        txFall && holdFull && state == aus_pkg::TX_IDLE |=> !serialOut;
    endproperty
    a_start_edge: assert property (p_start_edge) else $error("start bit missing after load");

    property p_no_early;
        state == aus_pkg::TX_IDLE && !txFall |=> serialOut;
    endproperty
    a_no_early: assert property (p_no_early) else $error("line left mark before a bit-clock edge");
endmodule

// ---- core/aus_rx.sv ----
// Receiver: start-bit detect and verify, then mid-bit sampling of the frame.
// Assumes a synchronised line level and one-cycle rising bit-clock pulses.
`timescale 1ns/1ps
`include "aus_params.svh"
module aus_rx (
    // Clock and block init
    input wire logic sys_clk,
    input wire logic init,
    // Line
    input wire logic rxRise,
    input wire logic line,
    // Character format
    aus_cfg_if.sink cfg,
    // Completed character
    output logic frameDone,
    output logic [7:0] frameData,
    output logic parityBad,
    output logic framingBad
);
    aus_pkg::aus_rx_state_t state;
    logic [3:0] cnt;
    logic [3:0] bitIdx;
    logic [7:0] shiftData;
    logic parSample;
    logic lastLine;
    logic [3:0] nBits;

    assign nBits = aus_pkg::wordBits(cfg.lenSel);

    always_ff @(posedge sys_clk) begin
        if (init) begin
            lastLine <= 1'b1;
        end else if (rxRise) begin
            lastLine <= line;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (init) begin
            state <= aus_pkg::RX_IDLE;
            cnt <= 4'h0;
            bitIdx <= 4'h0;
            shiftData <= 8'h00;
            parSample <= 1'b0;
            frameDone <= 1'b0;
            frameData <= 8'h00;
            parityBad <= 1'b0;
            framingBad <= 1'b0;
        end else begin
            frameDone <= 1'b0;
            if (rxRise) begin
                case (state)
                    aus_pkg::RX_IDLE: begin
                        if (lastLine && !line) begin
                            state <= aus_pkg::RX_VERIFY;
                            cnt <= 4'h0;
                        end
                    end
                    aus_pkg::RX_VERIFY: begin
                        if (line) begin
                            state <= aus_pkg::RX_IDLE;
                        end else if (cnt == `AUS_HALF_LAST) begin
                            state <= aus_pkg::RX_SHIFT;
                            cnt <= 4'h0;
                            bitIdx <= 4'h0;
                            shiftData <= 8'h00;
                        end else begin
                            cnt <= cnt + 4'h1;
                        end
                    end
                    aus_pkg::RX_SHIFT: begin
                        if (cnt != `AUS_TICK_LAST) begin
                            cnt <= cnt + 4'h1;
                        end else begin
                            cnt <= 4'h0;
                            bitIdx <= bitIdx + 4'h1;
                            if (bitIdx < nBits) begin
                                shiftData[bitIdx[2:0]] <= line;
                            end else if (cfg.parityOn && bitIdx == nBits) begin
                                parSample <= line;
                            end else begin
                                state <= aus_pkg::RX_IDLE;
                                frameDone <= 1'b1;
                                frameData <= shiftData;
                                framingBad <= !line;
                                parityBad <= cfg.parityOn
                                    && parSample != aus_pkg::parityBit(shiftData, nBits, cfg.parityEven);
                            end
                        end
                    end
                    default: state <= aus_pkg::RX_IDLE;
                endcase
            end
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (init);

    property p_detect;
        rxRise && state == aus_pkg::RX_IDLE && lastLine && !line |=> state == aus_pkg::RX_VERIFY;
    endproperty
    a_detect: assert property (p_detect) else $error("start edge not detected");

    property p_abort;
        rxRise && state == aus_pkg::RX_VERIFY && line |=> state == aus_pkg::RX_IDLE;
    endproperty
    a_abort: assert property (p_abort) else $error("false start bit not abandoned");

    property p_verify;
        $rose(state == aus_pkg::RX_SHIFT) |-> $past(cnt) == `AUS_HALF_LAST && !$past(line);
    endproperty
    a_verify: assert property (p_verify) else $error("start bit accepted before half a bit");

    property p_center;
        frameDone |-> $past(cnt) == `AUS_TICK_LAST;
    endproperty
    a_center: assert property (p_center) else $error("stop bit not sampled at bit centre");
endmodule

// ---- core/aus_uart_top.sv ----
// Pin-strapped full-duplex asynchronous serial block with a small interrupt register port.
// Assumes every strapped pin input is asynchronous to sys_clk, the register port is synchronous to it, and bit clocks run well below it.
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "aus_params.svh"
// Notes on behaviour
// - The start bit goes out at the first falling transmit bit-clock edge after the load strobe is released, or if busy at the edge ending the last stop bit.
// - From idle the start bit appears within one transmit bit-clock period of the strobe release.
// - A start bit is accepted only after the line stays low for half a bit time.
// - If the line returns high during that half bit, the receiver waits for a fresh falling edge.
// - A start edge is detected within one receive bit-clock period.
// - Flag and data outputs float unless their enables are low.
// - A character arriving while data-available is still set raises overrun, otherwise overrun is cleared.
// - The parity inputs select odd, even or no parity for both directions.
// - The word-length inputs select five to eight data bits.
// - Master init drives the line, done and empty flags high and clears the receive flags.
// - A low clear input clears data-available, the only sign that the character was read.
module aus_uart_top (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic master_init,
    // Bit clocks
    input wire logic tx_bit_clock_16x,
    input wire logic rx_bit_clock_16x,
    // Transmit side
    input wire logic [7:0] tx_data,
    input wire logic tx_load_strobe_n,
    output logic tx_serial_out,
    output logic tx_char_done,
    // Character format
    input wire logic ctrl_strobe,
    input wire logic parity_omit,
    input wire logic parity_sense_select,
    input wire logic word_len_sel_lo,
    input wire logic word_len_sel_hi,
    input wire logic stop_bits_two,
    // Receive side
    input wire logic rx_serial_in,
    input wire logic rx_avail_clear_n,
    // Three-state flag outputs
    input wire logic flags_out_enable_n,
    output logic tx_holding_empty,
    output logic rx_char_available,
    output logic rx_overrun_flag,
    output logic rx_parity_err_flag,
    output logic rx_framing_err_flag,
    output logic flagsOeN,
    // Three-state character outputs
    input wire logic rx_char_out_enable_n,
    output logic [7:0] rx_char_data,
    output logic rxCharOeN,
    // Register port and interrupt
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    output logic irq
);
    aus_pkg::aus_pins_t pinS1;
    aus_pkg::aus_pins_t pinS2;
    logic init;
    logic txClkD;
    logic rxClkD;
    logic loadD;
    logic txFall;
    logic txRise;
    logic rxRise;
    logic [4:0] cfgReg;
    logic txSerial;
    logic txDone;
    logic txDoneD;
    logic txEmpty;
    logic frameDone;
    logic [7:0] frameData;
    logic parityBad;
    logic framingBad;
    logic rxAvail;
    logic rxOverrun;
    logic rxPerr;
    logic rxFerr;
    logic [7:0] rxBuf;
    logic [`AUS_ST_W-1:0] status;
    logic [`AUS_ST_W-1:0] mask;
    logic [`AUS_ST_W-1:0] events;

    aus_cfg_if cfg ();

    // Resetting the synchronisers to all ones keeps the load strobe and clear idle, the line at mark
    // and master init asserted until real pin levels have passed both stages.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pinS1 <= '1;
            pinS2 <= '1;
        end else begin
            pinS1.initIn <= master_init;
            pinS1.txClk <= tx_bit_clock_16x;
            pinS1.rxClk <= rx_bit_clock_16x;
            pinS1.txData <= tx_data;
            pinS1.loadN <= tx_load_strobe_n;
            pinS1.ctrlStb <= ctrl_strobe;
            pinS1.parOmit <= parity_omit;
            pinS1.parSel <= parity_sense_select;
            pinS1.lenLo <= word_len_sel_lo;
            pinS1.lenHi <= word_len_sel_hi;
            pinS1.stopTwo <= stop_bits_two;
            pinS1.rxIn <= rx_serial_in;
            pinS1.clrN <= rx_avail_clear_n;
            pinS1.flagsEnN <= flags_out_enable_n;
            pinS1.dataEnN <= rx_char_out_enable_n;
            pinS2 <= pinS1;
        end
    end

    assign init = !resetn || pinS2.initIn;

    always_ff @(posedge sys_clk) begin
        if (init) begin
            txClkD <= 1'b1;
            rxClkD <= 1'b1;
            loadD <= 1'b1;
        end else begin
            txClkD <= pinS2.txClk;
            rxClkD <= pinS2.rxClk;
            loadD <= pinS2.loadN;
        end
    end

    assign txFall = txClkD && !pinS2.txClk;
    assign txRise = !txClkD && pinS2.txClk;
    assign rxRise = !rxClkD && pinS2.rxClk;

    // A control strobe tied high simply follows the format pins.
    always_ff @(posedge sys_clk) begin
        if (init) begin
            cfgReg <= 5'h00;
        end else if (pinS2.ctrlStb) begin
            cfgReg <= {pinS2.stopTwo, pinS2.parOmit, pinS2.parSel, pinS2.lenHi, pinS2.lenLo};
        end
    end

    assign cfg.lenSel = cfgReg[1:0];
    assign cfg.parityEven = cfgReg[2];
    assign cfg.parityOn = !cfgReg[3];
    assign cfg.twoStop = cfgReg[4];

    aus_tx u_tx (
        .sys_clk(sys_clk),
        .init(init),
        .txFall(txFall),
        .txRise(txRise),
        .loadLow(!pinS2.loadN),
        .loadRelease(!loadD && pinS2.loadN),
        .loadData(pinS2.txData),
        .cfg(cfg.sink),
        .serialOut(txSerial),
        .charDone(txDone),
        .holdEmpty(txEmpty)
    );

    aus_rx u_rx (
        .sys_clk(sys_clk),
        .init(init),
        .rxRise(rxRise),
        .line(pinS2.rxIn),
        .cfg(cfg.sink),
        .frameDone(frameDone),
        .frameData(frameData),
        .parityBad(parityBad),
        .framingBad(framingBad)
    );

    // Receive buffer; a new character wins over a clear in the same cycle.
    always_ff @(posedge sys_clk) begin
        if (init) begin
            rxAvail <= 1'b0;
            rxOverrun <= 1'b0;
            rxPerr <= 1'b0;
            rxFerr <= 1'b0;
            rxBuf <= 8'h00;
        end else begin
            if (!pinS2.clrN) rxAvail <= 1'b0;
            if (frameDone) begin
                rxAvail <= 1'b1;
                rxOverrun <= rxAvail;
                rxPerr <= parityBad;
                rxFerr <= framingBad;
                rxBuf <= frameData;
            end
        end
    end

    // Output stage; the enables steer the three-state drivers outside.
    always_ff @(posedge sys_clk) begin
        if (init) begin
            tx_serial_out <= 1'b1;
            tx_char_done <= 1'b1;
            tx_holding_empty <= 1'b1;
            rx_char_available <= 1'b0;
            rx_overrun_flag <= 1'b0;
            rx_parity_err_flag <= 1'b0;
            rx_framing_err_flag <= 1'b0;
            rx_char_data <= 8'h00;
            flagsOeN <= 1'b1;
            rxCharOeN <= 1'b1;
        end else begin
            tx_serial_out <= txSerial;
            tx_char_done <= txDone;
            tx_holding_empty <= txEmpty;
            rx_char_available <= rxAvail;
            rx_overrun_flag <= rxOverrun;
            rx_parity_err_flag <= rxPerr;
            rx_framing_err_flag <= rxFerr;
            rx_char_data <= rxBuf;
            flagsOeN <= pinS2.flagsEnN;
            rxCharOeN <= pinS2.dataEnN;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (init) begin
            txDoneD <= 1'b1;
        end else begin
            txDoneD <= txDone;
        end
    end

    always_comb begin
        events = '0;
        events[`AUS_ST_RXAVAIL] = frameDone;
        events[`AUS_ST_OVERRUN] = frameDone && rxAvail;
        events[`AUS_ST_PARITY] = frameDone && parityBad;
        events[`AUS_ST_FRAMING] = frameDone && framingBad;
        events[`AUS_ST_TXDONE] = txDone && !txDoneD;
    end

    // Reading status clears it, but an event in that same cycle stays set.
    always_ff @(posedge sys_clk) begin
        if (init) begin
            status <= '0;
        end else if (regRd && regAddr == `AUS_REG_STATUS) begin
            status <= events;
        end else begin
            status <= status | events;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (init) begin
            mask <= `AUS_MASK_RST;
        end else if (regWr && regAddr == `AUS_REG_MASK) begin
            mask <= regWdata[`AUS_ST_W-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (init) begin
            regRdata <= 8'h00;
        end else if (regRd && regAddr == `AUS_REG_STATUS) begin
            regRdata <= {3'h0, status};
        end else if (regRd && regAddr == `AUS_REG_MASK) begin
            regRdata <= {3'h0, mask};
        end else begin
            regRdata <= 8'h00;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (init) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask);
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    property p_ovr_set;
        !pinS2.initIn && frameDone && rxAvail |=> ##1 rx_overrun_flag;
    endproperty
    a_ovr_set: assert property (p_ovr_set) else $error("overrun not raised");

    property p_ovr_clr;
        !pinS2.initIn && frameDone && !rxAvail |=> ##1 !rx_overrun_flag;
    endproperty
    a_ovr_clr: assert property (p_ovr_clr) else $error("overrun raised without cause");

    property p_avail_clr;
        !pinS2.initIn && !pinS2.clrN && !frameDone |=> ##1 !rx_char_available;
    endproperty
    a_avail_clr: assert property (p_avail_clr) else $error("data-available not cleared");

    property p_float;
        pinS2.flagsEnN && pinS2.dataEnN |=> flagsOeN && rxCharOeN;
    endproperty
    a_float: assert property (p_float) else $error("outputs driven while disabled");

    property p_init;
        pinS2.initIn ##1 pinS2.initIn |=> tx_serial_out && tx_char_done && tx_holding_empty
            && !rx_char_available && !rx_overrun_flag && !rx_parity_err_flag && !rx_framing_err_flag;
    endproperty
    a_init: assert property (p_init) else $error("master init values wrong");

    property p_parity_cfg;
        !pinS2.initIn && pinS2.ctrlStb |=> cfg.parityOn == !$past(pinS2.parOmit) && cfg.parityEven == $past(pinS2.parSel);
    endproperty
    a_parity_cfg: assert property (p_parity_cfg) else $error("parity mode not latched");

    property p_len_cfg;
        !pinS2.initIn && pinS2.ctrlStb |=> cfg.lenSel == $past({pinS2.lenHi, pinS2.lenLo});
    endproperty
    a_len_cfg: assert property (p_len_cfg) else $error("word length not latched");

    c_overrun: cover property ($rose(rx_overrun_flag));
    c_framing: cover property ($rose(rx_framing_err_flag));
    c_tx_start: cover property ($fell(tx_serial_out));
    c_irq: cover property ($rose(irq));
endmodule

// ---- test/aus_line_peer.sv ----
// Far-end serial transmitter that drives the receive line of the block.
// Assumes the bench supplies the 16x receive bit clock as a level.
`timescale 1ns/1ps
module aus_line_peer (
    // Receive bit clock
    input wire logic rxClk,
    // Line toward the block, idles at mark
    output logic line = 1'b1
);
    task automatic tick(input int n);
        repeat (n) @(posedge rxClk);
    endtask
    // Mode 0 odd, 1 even, 2 none; flip sends a wrong parity bit.
    task automatic sendChar(input logic [7:0] d, input int n, input int mode, input logic flip);
        logic [7:0] m;
        m = d & ((8'h01 << n) - 8'h01);
        line <= 1'b0;
        tick(16);
        for (int i = 0; i < n; i++) begin
            line <= d[i];
            tick(16);
        end
        if (mode != 2) begin
            line <= ^m ^ (mode == 0) ^ flip;
            tick(16);
        end
        line <= 1'b1;
        tick(20);
    endtask
    // A low pulse shorter than half a bit, so the receiver must drop it.
    task automatic glitch();
        line <= 1'b0;
        tick(5);
        line <= 1'b1;
        tick(20);
    endtask
endmodule

// ---- test/aus_uart_top_bench.sv ----
// Self-checking bench of the serial block with a far-end line model.
// Assumes both bit clocks share one divided clock of 8 system cycles.
`timescale 1ns/1ps
module aus_uart_top_bench;
    logic sys_clk = 1'b0, resetn = 1'b0, bitClk = 1'b0, loadN = 1'b1, clrN = 1'b1, enN = 1'b0;
    logic pOmit = 1'b0, pSel = 1'b0, lLo = 1'b0, lHi = 1'b0, regWr = 1'b0, regRd = 1'b0, prevA, prevO;
    logic [7:0] txData = 8'h00, regWdata = 8'h00, d, rxData, regRdata;
    logic [3:0] regAddr = 4'h0, div = 4'h0;
    logic [31:0] seed = 32'h00013C6A;
    logic [10:0] expQ[$];
    logic txOut, txDone, holdE, avail, ovr, parErr, frmErr, flOe, dOe, irq, rxLine;
    int mismatches = 0, nCompared = 0, n, mode, k;
    aus_uart_top u_aus_uart_top (.sys_clk(sys_clk), .resetn(resetn), .master_init(1'b0),
        .tx_bit_clock_16x(bitClk), .rx_bit_clock_16x(bitClk), .tx_data(txData), .tx_load_strobe_n(loadN),
        .tx_serial_out(txOut), .tx_char_done(txDone), .ctrl_strobe(1'b1), .parity_omit(pOmit),
        .parity_sense_select(pSel), .word_len_sel_lo(lLo), .word_len_sel_hi(lHi), .stop_bits_two(1'b0),
        .rx_serial_in(rxLine), .rx_avail_clear_n(clrN), .flags_out_enable_n(enN), .tx_holding_empty(holdE),
        .rx_char_available(avail), .rx_overrun_flag(ovr), .rx_parity_err_flag(parErr),
        .rx_framing_err_flag(frmErr), .flagsOeN(flOe), .rx_char_out_enable_n(enN), .rx_char_data(rxData),
        .rxCharOeN(dOe), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .irq(irq));
    aus_line_peer u_aus_line_peer (.rxClk(bitClk), .line(rxLine));
    initial forever #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        div <= div + 4'h1;
        bitClk <= div[2];
        prevA <= avail;
        prevO <= ovr;
        if ((avail && !prevA) || (ovr && !prevO))
            check("rx char", {frmErr, ovr, parErr, rxData}, expQ.size() ? expQ.pop_front() : 11'h7FF);
    end
    function automatic logic [7:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
        nCompared++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic regAcc(input logic wr, input logic [3:0] a, input logic [7:0] v);
        regAddr <= a;
        regWdata <= v;
        regWr <= wr;
        regRd <= !wr;
        @(posedge sys_clk);
        regWr <= 1'b0;
        regRd <= 1'b0;
        #1 if (!wr) check("regRdata", {3'h0, regRdata}, {3'h0, v});
        @(posedge sys_clk);
    endtask
    task automatic wrapUp();
        $display("compared %0d mismatches %0d", nCompared, mismatches);
        if (mismatches == 0 && nCompared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge sys_clk);
        mismatches++;
        wrapUp();
    end
    initial begin
        repeat (19) @(posedge sys_clk);
        #1 check("idle", {4'h0, txOut, txDone, holdE, avail, ovr, parErr, frmErr}, 11'h070);
        @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        regAcc(1'b1, 4'h4, 8'h01);
        regAcc(1'b0, 4'h4, 8'h01);
        regAcc(1'b0, 4'h8, 8'h00);
        for (int i = 0; i < 4; i++) begin
            n = 5 + i;
            mode = i % 3;
            {lHi, lLo} <= i[1:0];
            pOmit <= (mode == 2);
            pSel <= (mode == 1);
            d = xs();
            txData <= d;
            loadN <= 1'b0;
            repeat (3) @(posedge sys_clk);
            loadN <= 1'b1;
            k = 0;
            #1 while (txOut === 1'b1 && k < 24) begin
                @(posedge sys_clk);
                #1 k++;
            end
            check("start delay", {10'h0, k < 16}, 11'h001);
            repeat (64) @(posedge sys_clk);
            d = d & ((8'h01 << n) - 8'h01);
            for (int b = 0; b < n + (mode != 2) + 2; b++) begin
                #1 check("tx bit", {10'h0, txOut}, {10'h0, b == 0 ? 1'b0 : b <= n ? d[b-1] :
                    (b == n + 1 && mode != 2) ? ^d ^ (mode == 0) : 1'b1});
                repeat (128) @(posedge sys_clk);
            end
            #1 check("tx done", {9'h0, txDone, holdE}, 11'h003);
            expQ.push_back({3'h0, d});
            u_aus_line_peer.sendChar(d, n, mode, 1'b0);
            repeat (8) @(posedge sys_clk);
            #1 check("irq", {10'h0, irq}, 11'h001);
            @(posedge sys_clk);
            regAcc(1'b0, 4'h0, 8'h11);
            clrN <= 1'b0;
            repeat (3) @(posedge sys_clk);
            clrN <= 1'b1;
            repeat (4) @(posedge sys_clk);
            #1 check("avail cleared", {7'h0, avail, irq, flOe, dOe}, 11'h000);
        end
        d = xs();
        expQ.push_back({3'h0, d});
        expQ.push_back({3'h3, ~d});
        u_aus_line_peer.sendChar(d, 8, 0, 1'b0);
        u_aus_line_peer.sendChar(~d, 8, 0, 1'b1);
        clrN <= 1'b0;
        repeat (3) @(posedge sys_clk);
        clrN <= 1'b1;
        u_aus_line_peer.glitch();
        expQ.push_back({3'h0, d});
        u_aus_line_peer.sendChar(d, 8, 0, 1'b0);
        @(posedge sys_clk);
        enN <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 check("enables", {9'h0, flOe, dOe}, 11'h003);
        check("queue", expQ.size(), 11'h000);
        wrapUp();
    end
endmodule
